// ==== rtl/pin_irq_defines.vh ====
// Register offsets, field positions, reset values for the pin edge interrupt block
`ifndef PIN_IRQ_DEFINES_VH
`define PIN_IRQ_DEFINES_VH
`define PIN_COUNT 23
`define PIN_MASK 32'h007fffff
`define OFF_ENABLE 8'h00
`define OFF_FUNCTION 8'h04
`define OFF_DIRECTION 8'h08
`define OFF_EDGE_SELECT 8'h0c
`define OFF_PENDING 8'h10
`define OFF_CLEAR_ALIAS 8'h14
`define OFF_SUMMARY 8'h18
`define OFF_SUMMARY_MASK 8'h1c
`define SUMMARY_GPIO_BIT 0
`define RST_PINS 23'h000000
`define RST_WORD 32'h00000000
`endif

// ==== rtl/pin_edge_interrupt_status.v ====
// Edge-detect pin interrupt status block with Avalon-MM register slave
//
// Notes on behaviour
// [RULE1] Select bit 0: rising edge interrupts
// [RULE2] Select bit 1: falling edge interrupts
// [RULE3] Bits 19-0 data, 20-22 control pins
// [RULE4] Pending needs enable, function, input, edge
// [RULE5] Any pending set sets summary bit
// [RULE6] Clear alias: one clears, zero keeps
// [RULE7] Summary bit clears only explicitly
// [RULE8] Summary sets again if pending remains
// [RULE9] Pending register ignores direct writes
// [RULE10] Bits 31-23 read zero, writes ignored
// [RULE11] Pending one means interrupt pending
// [RULE12] Reset clears edge select and pending
// [RULE13] Clear alias reads back all zeros
// [RULE14] Only enabled pins set pending
// [RULE15] Synchronise pins, one set per edge
`timescale 1ns/1ps
`include "pin_irq_defines.vh"

module pin_edge_interrupt_status #(
  parameter N = `PIN_COUNT
) (
  input wire MCLK,
  input wire RESET,
  input wire [N-1:0] PIN_IN,
  input wire [7:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  output reg [31:0] AVS_READDATA,
  output reg AVS_WAITREQUEST,
  output reg IRQ
);

// ----------------------------------------
// Pin synchronisers and edge detection
// ----------------------------------------
reg [N-1:0] sync1_reg;
reg [N-1:0] sync2_reg;
reg [N-1:0] prev_reg;
reg [N-1:0] pin_irq_enable_reg;
reg [N-1:0] pin_function_select_reg;
reg [N-1:0] pin_direction_reg;
reg [N-1:0] pin_irq_edge_select_reg;
reg [N-1:0] pin_irq_pending_reg;
reg [N-1:0] pin_irq_pending_next;
reg summary_reg;
reg summary_next;
reg summary_mask_reg;
reg ack_reg;
reg [31:0] rdata_next;
wire [N-1:0] rise;
wire [N-1:0] fall;
wire [N-1:0] edge_hit;
wire [N-1:0] armed;
wire [N-1:0] clr_bits;
wire wr_go;
wire rd_go;
wire req_new;
wire wr_enable;
wire wr_function;
wire wr_direction;
wire wr_edge_select;
wire wr_summary;
wire wr_summary_mask;
wire wr_clear_alias;
wire summary_clear;
wire [N-1:0] pin_hits;

// ----------------------------------------
// Helper functions
// ----------------------------------------
// True when the bus address selects the register
function addr_is;
  input [7:0] addr;
  input [7:0] sel_offset;
  begin
    addr_is = (addr == sel_offset);
  end
endfunction

// Pin field of a bus word
function [N-1:0] pin_field;
  input [31:0] word;
  begin
    pin_field = word[N-1:0];
  end
endfunction

// Bus word from a pin field, reserved bits zero
function [31:0] pin_word;
  input [N-1:0] pins;
  begin
    pin_word = `RST_WORD;
    pin_word[N-1:0] = pins; // RULE10
  end
endfunction

// Not reset, so no false edge follows reset release
always @(posedge MCLK)
begin
  sync1_reg <= PIN_IN; // RULE15
  sync2_reg <= sync1_reg;
  prev_reg <= sync2_reg;
end

assign rise = sync2_reg & ~prev_reg; // RULE15
assign fall = ~sync2_reg & prev_reg;
assign edge_hit = (~pin_irq_edge_select_reg & rise) | (pin_irq_edge_select_reg & fall); // RULE1 RULE2 RULE3
// Function bit 1 = GPIO, direction bit 0 = input
assign armed = pin_irq_enable_reg & pin_function_select_reg & ~pin_direction_reg; // RULE4 RULE14
assign pin_hits = edge_hit & armed; // RULE4 RULE14

// ----------------------------------------
// Bus handshake
// ----------------------------------------
// One wait cycle, then ack for one cycle
assign req_new = (AVS_READ | AVS_WRITE) & ~ack_reg;
assign wr_go = AVS_WRITE & ack_reg;
assign rd_go = AVS_READ & ~ack_reg;

// ----------------------------------------
// Write decode
// ----------------------------------------
assign wr_enable = wr_go & addr_is(AVS_ADDRESS, `OFF_ENABLE);
assign wr_function = wr_go & addr_is(AVS_ADDRESS, `OFF_FUNCTION);
assign wr_direction = wr_go & addr_is(AVS_ADDRESS, `OFF_DIRECTION);
assign wr_edge_select = wr_go & addr_is(AVS_ADDRESS, `OFF_EDGE_SELECT); // RULE10
assign wr_clear_alias = wr_go & addr_is(AVS_ADDRESS, `OFF_CLEAR_ALIAS); // RULE6
assign wr_summary = wr_go & addr_is(AVS_ADDRESS, `OFF_SUMMARY);
assign wr_summary_mask = wr_go & addr_is(AVS_ADDRESS, `OFF_SUMMARY_MASK);
assign clr_bits = wr_clear_alias ? pin_field(AVS_WRITEDATA) : `RST_PINS; // RULE6
assign summary_clear = wr_summary & AVS_WRITEDATA[`SUMMARY_GPIO_BIT]; // RULE7

// ----------------------------------------
// Pending and summary next state
// ----------------------------------------
always @*
begin
  // Set wins over clear
  pin_irq_pending_next = (pin_irq_pending_reg & ~clr_bits) | pin_hits; // RULE4 RULE6 RULE9 RULE11
  summary_next = summary_reg;
  if (summary_clear)
  begin
    summary_next = 1'b0; // RULE7
  end
  if ((|pin_irq_pending_reg) || (|pin_hits))
  begin
    summary_next = 1'b1; // RULE5 RULE8
  end
end

// ----------------------------------------
// Read mux
// ----------------------------------------
always @*
begin
  rdata_next = `RST_WORD;
  if (addr_is(AVS_ADDRESS, `OFF_ENABLE))
  begin
    rdata_next = pin_word(pin_irq_enable_reg);
  end
  else if (addr_is(AVS_ADDRESS, `OFF_FUNCTION))
  begin
    rdata_next = pin_word(pin_function_select_reg);
  end
  else if (addr_is(AVS_ADDRESS, `OFF_DIRECTION))
  begin
    rdata_next = pin_word(pin_direction_reg);
  end
  else if (addr_is(AVS_ADDRESS, `OFF_EDGE_SELECT))
  begin
    rdata_next = pin_word(pin_irq_edge_select_reg); // RULE10
  end
  else if (addr_is(AVS_ADDRESS, `OFF_PENDING))
  begin
    rdata_next = pin_word(pin_irq_pending_reg); // RULE10 RULE11
  end
  else if (addr_is(AVS_ADDRESS, `OFF_SUMMARY))
  begin
    rdata_next[`SUMMARY_GPIO_BIT] = summary_reg;
  end
  else if (addr_is(AVS_ADDRESS, `OFF_SUMMARY_MASK))
  begin
    rdata_next[`SUMMARY_GPIO_BIT] = summary_mask_reg;
  end
  else
  begin
    rdata_next = `RST_WORD; // RULE13
  end
end

// ----------------------------------------
// Configuration registers
// ----------------------------------------
always @(posedge MCLK)
begin
  if (RESET)
  begin
    pin_irq_enable_reg <= `RST_PINS;
  end
  else if (wr_enable)
  begin
    pin_irq_enable_reg <= pin_field(AVS_WRITEDATA); // RULE14
  end
end

always @(posedge MCLK)
begin
  if (RESET)
  begin
    pin_function_select_reg <= `RST_PINS;
  end
  else if (wr_function)
  begin
    pin_function_select_reg <= pin_field(AVS_WRITEDATA);
  end
end

always @(posedge MCLK)
begin
  if (RESET)
  begin
    pin_direction_reg <= `RST_PINS;
  end
  else if (wr_direction)
  begin
    pin_direction_reg <= pin_field(AVS_WRITEDATA);
  end
end

always @(posedge MCLK)
begin
  if (RESET)
  begin
    pin_irq_edge_select_reg <= `RST_PINS; // RULE12
  end
  else if (wr_edge_select)
  begin
    pin_irq_edge_select_reg <= pin_field(AVS_WRITEDATA); // RULE10
  end
end

always @(posedge MCLK)
begin
  if (RESET)
  begin
    summary_mask_reg <= 1'b0;
  end
  else if (wr_summary_mask)
  begin
    summary_mask_reg <= AVS_WRITEDATA[`SUMMARY_GPIO_BIT];
  end
end

// ----------------------------------------
// Status and bus response registers
// ----------------------------------------
always @(posedge MCLK)
begin
  if (RESET)
  begin
    pin_irq_pending_reg <= `RST_PINS; // RULE12
  end
  else
  begin
    pin_irq_pending_reg <= pin_irq_pending_next; // RULE9
  end
end

always @(posedge MCLK)
begin
  if (RESET)
  begin
    summary_reg <= 1'b0;
  end
  else
  begin
    summary_reg <= summary_next;
  end
end

always @(posedge MCLK)
begin
  if (RESET)
  begin
    IRQ <= 1'b0;
  end
  else
  begin
    IRQ <= summary_next & summary_mask_reg;
  end
end

always @(posedge MCLK)
begin
  if (RESET)
  begin
    ack_reg <= 1'b0;
  end
  else
  begin
    ack_reg <= req_new;
  end
end

always @(posedge MCLK)
begin
  if (RESET)
  begin
    AVS_WAITREQUEST <= 1'b1;
  end
  else
  begin
    AVS_WAITREQUEST <= ~req_new;
  end
end

always @(posedge MCLK)
begin
  if (RESET)
  begin
    AVS_READDATA <= `RST_WORD;
  end
  else if (rd_go)
  begin
    AVS_READDATA <= rdata_next;
  end
end

endmodule // pin_edge_interrupt_status

// ==== dv/pin_level_model.sv ====
// Pin level model for the general-purpose pins
`timescale 1ns/1ps
module pin_level_model (
  input wire MCLK,
  output logic [22:0] PIN_IN
);
  initial PIN_IN = 23'h000002;
  task drive(input [22:0] v);
    @(posedge MCLK);
    PIN_IN <= v;
  endtask
endmodule // pin_level_model

// ==== dv/pin_irq_monitor.sv ====
// Port checker for the pin edge interrupt block
`timescale 1ns/1ps
module pin_irq_monitor (
  input wire MCLK,
  input wire RESET,
  input wire [7:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_READDATA,
  input wire AVS_WAITREQUEST,
  input wire IRQ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  wire r = AVS_READ || AVS_WRITE;
  wire rd = AVS_READ && !AVS_WAITREQUEST;
  sequence s_acc; r && AVS_WAITREQUEST ##1 !AVS_WAITREQUEST; endsequence
  property p_ans; r && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_pulse; s_acc |=> AVS_WAITREQUEST; endproperty
  a_pulse: assert property (p_pulse) else $error("wait low too long");
  property p_idle; !r && AVS_WAITREQUEST |=> AVS_WAITREQUEST; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_alias; rd && AVS_ADDRESS == 8'h14 |-> AVS_READDATA == 32'h0; endproperty
  a_alias: assert property (p_alias) else $error("alias read nonzero");
  property p_resv; rd |-> AVS_READDATA[31:23] == 9'h0; endproperty
  a_resv: assert property (p_resv) else $error("upper bits nonzero");
  property p_unmap; rd && AVS_ADDRESS > 8'h1c |-> AVS_READDATA == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
  property p_hold; !AVS_READ |=> $stable(AVS_READDATA); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_fall; $fell(IRQ) |-> $past(AVS_WRITE) || $past(AVS_WRITE, 2); endproperty
  a_fall: assert property (p_fall) else $error("irq dropped alone");
endmodule // pin_irq_monitor
bind pin_edge_interrupt_status pin_irq_monitor u_mon(.MCLK(MCLK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ));

// ==== dv/testbench.sv ====
// Register level testbench for the pin edge interrupt block
`timescale 1ns/1ps
module testbench;
  logic MCLK = 0, RESET = 1, AVS_READ = 0, AVS_WRITE = 0;
  logic [7:0] AVS_ADDRESS = 8'h00;
  logic [31:0] AVS_WRITEDATA = 32'h0, q;
  wire [22:0] pin;
  wire [31:0] rdata;
  wire wq, irq;
  integer fail_count = 0, cmp_count = 0;
  always #12.5 MCLK = ~MCLK;
  pin_edge_interrupt_status u_dut(.MCLK(MCLK), .RESET(RESET), .PIN_IN(pin), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wq), .IRQ(irq));
  pin_level_model u_pins(.MCLK(MCLK), .PIN_IN(pin));
  task chk(input string nm, input [31:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task acc(input w, input [7:0] a, input [31:0] d);
    @(posedge MCLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    do @(posedge MCLK); while (wq !== 1'b0);
    q = rdata;
    AVS_WRITE <= 0;
    AVS_READ <= 0;
  endtask
  task rc(input [7:0] a, input [31:0] e, input string nm);
    acc(0, a, 0);
    chk(nm, q, e);
  endtask
  task conclude;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (3000) @(posedge MCLK);
    fail_count++;
    conclude;
  end
  initial
  begin
    repeat (16) @(posedge MCLK);
    RESET <= 0;
    rc(8'h0c, 0, "sel");
    rc(8'h10, 0, "pend");
    acc(1, 8'h0c, 32'hffffffff);
    rc(8'h0c, 32'h007fffff, "sel");
    acc(1, 8'h0c, 32'h2);
    acc(1, 8'h00, 32'h00400007);
    acc(1, 8'h04, 32'h0040000b);
    acc(1, 8'h08, 32'h1);
    acc(1, 8'h1c, 32'h1);
    u_pins.drive(23'h40000d);
    repeat (10) @(posedge MCLK);
    rc(8'h10, 32'h00400002, "pend");
    chk("irq", {31'h0, irq}, 1);
    acc(1, 8'h10, 32'h0);
    rc(8'h10, 32'h00400002, "pend");
    acc(1, 8'h14, 32'h2);
    rc(8'h10, 32'h00400000, "pend");
    rc(8'h14, 0, "alias");
    acc(1, 8'h18, 32'h1);
    rc(8'h18, 1, "sum");
    acc(1, 8'h1c, 32'h0);
    rc(8'h1c, 0, "mask");
    chk("irq", {31'h0, irq}, 0);
    acc(1, 8'h1c, 32'h1);
    rc(8'h1c, 1, "mask");
    chk("irq", {31'h0, irq}, 1);
    acc(1, 8'h14, 32'hffffffff);
    rc(8'h10, 0, "pend");
    rc(8'h18, 1, "sum");
    acc(1, 8'h18, 32'h1);
    rc(8'h18, 0, "sum");
    u_pins.drive(23'h000002);
    repeat (10) @(posedge MCLK);
    rc(8'h10, 0, "pend");
    chk("irq", {31'h0, irq}, 0);
    u_pins.drive(23'h40000d);
    repeat (10) @(posedge MCLK);
    rc(8'h10, 32'h00400002, "pend");
    RESET <= 1;
    repeat (4) @(posedge MCLK);
    RESET <= 0;
    rc(8'h10, 0, "pend");
    rc(8'h0c, 0, "sel");
    chk("irq", {31'h0, irq}, 0);
    rc(8'h40, 0, "unmap");
    conclude;
  end
endmodule // testbench
